// ===== design/rtc_i2c_consts.vh
// Constants for the real-time clock serial target access block.
`ifndef RTC_I2C_CONSTS_VH
`define RTC_I2C_CONSTS_VH
`define RTC_BYTE_W      8
`define RTC_PTR_W       5
`define RTC_PTR_RESET   5'h00
`define RTC_PTR_TOP     5'h1F
`define RTC_FIFO_DEPTH  8
`define RTC_FIFO_AW     3
`define RTC_BIT_CNT_W   4
`define RTC_BITS_DONE   4'h8
`define RTC_DIR_READ    1'b1
`define RTC_DEV_ID      7'h2A
`endif

// ===== design/rtc_i2c_target_access.v
// Serial bus target logic with a write FIFO for a real-time clock register array.
`timescale 1ns/1ps
`include "rtc_i2c_consts.vh"

module rtc_write_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = `RTC_FIFO_DEPTH,
  parameter AW    = `RTC_FIFO_AW
) (
  input  wire             clk_in,    // Block clock.
  input  wire             rst_in,    // Asynchronous reset, active high.
  input  wire             in_valid,  // Word offered.
  output wire             in_ready,  // Room for a word.
  input  wire [WIDTH-1:0] in_data,   // Word to store.
  output wire             out_valid, // Word available.
  input  wire             out_ready, // Consumer takes the word.
  output wire [WIDTH-1:0] out_data   // Oldest word.
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

module rtc_i2c_target_access #(
  parameter [6:0] DEVICE_ID = `RTC_DEV_ID // Value is arbitrary; set per product.
) (
  input  wire                  clk_in,       // 25 MHz block clock.
  input  wire                  rst_in,       // Asynchronous reset, active high.
  input  wire                  scl_in,       // Serial clock pin level.
  input  wire                  sda_in,       // Serial data pin level.
  output wire                  sda_out,      // Serial data drive value, always low.
  output reg                   sda_oe_out,   // High while pulling serial data low.
  output reg  [`RTC_PTR_W-1:0] rd_addr_out,  // Register pointer for read data.
  input  wire [7:0]            rd_data_in,   // Register content at rd_addr_out.
  output wire                  wr_valid_out, // Register write waiting.
  input  wire                  wr_ready_in,  // Register array accepts the write.
  output wire [`RTC_PTR_W-1:0] wr_addr_out,  // Register written.
  output wire [7:0]            wr_data_out,  // Byte written.
  output wire                  busy_out      // Set at a start, cleared at a stop or when the transfer is ignored.
);
  localparam [9:0] ST_IDLE = 10'h001;
  localparam [9:0] ST_DEV  = 10'h002;
  localparam [9:0] ST_DACK = 10'h004;
  localparam [9:0] ST_REG  = 10'h008;
  localparam [9:0] ST_RACK = 10'h010;
  localparam [9:0] ST_WDAT = 10'h020;
  localparam [9:0] ST_WACK = 10'h040;
  localparam [9:0] ST_TX   = 10'h080;
  localparam [9:0] ST_MACK = 10'h100;
  localparam [9:0] ST_IGN  = 10'h200;

  reg [2:0]                scl_sync;
  reg [2:0]                sda_sync;
  reg [9:0]                state;
  reg [`RTC_BIT_CNT_W-1:0] bit_cnt;
  reg [7:0]                shreg;
  reg                      is_read;
  reg                      master_ack;
  wire                     scl_rise;
  wire                     scl_fall;
  wire                     start_seen;
  wire                     stop_seen;
  wire                     byte_done;
  wire                     fifo_ready;
  wire                     fifo_push;

  // The pointer steps one past the top back to zero.
  function [`RTC_PTR_W-1:0] ptr_step;
    input [`RTC_PTR_W-1:0] p;
    begin
      ptr_step = (p == `RTC_PTR_TOP) ? `RTC_PTR_RESET : p + 1'b1;
    end
  endfunction

  // Only the second and third stages are looked at, so metastability stays in stage one.
  assign scl_rise   = scl_sync[1] & ~scl_sync[2];
  assign scl_fall   = ~scl_sync[1] & scl_sync[2];
  assign start_seen = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
  assign stop_seen  = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];
  assign byte_done  = (bit_cnt == `RTC_BITS_DONE);
  assign sda_out    = 1'b0;
  assign busy_out   = ~state[0] & ~state[9];
  assign fifo_push  = (state == ST_WDAT) & scl_fall & byte_done & fifo_ready;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state       <= ST_IDLE;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      is_read     <= 1'b0;
      master_ack  <= 1'b0;
      sda_oe_out  <= 1'b0;
      rd_addr_out <= `RTC_PTR_RESET;
    end else if (start_seen) begin
      // A repeated start keeps the pointer, which is what a random read relies on.
      state      <= ST_DEV;
      bit_cnt    <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (stop_seen) begin
      state      <= ST_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      case (state)
        ST_DEV, ST_REG, ST_WDAT: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_sync[2]};
            bit_cnt <= bit_cnt + 1'b1;
          end else if (scl_fall & byte_done) begin
            bit_cnt <= 4'h0;
            if (state == ST_DEV) begin
              if (shreg[7:1] == DEVICE_ID) begin
                is_read    <= (shreg[0] == `RTC_DIR_READ);
                sda_oe_out <= 1'b1;
                state      <= ST_DACK;
              end else begin
                state <= ST_IGN;
              end
            end else if (state == ST_REG) begin
              rd_addr_out <= shreg[`RTC_PTR_W-1:0];
              sda_oe_out  <= 1'b1;
              state       <= ST_RACK;
            end else if (fifo_ready) begin
              sda_oe_out <= 1'b1;
              state      <= ST_WACK;
            end else begin
              // With the write FIFO full the byte is refused rather than lost silently.
              state <= ST_IGN;
            end
          end
        end
        ST_DACK: begin
          if (scl_fall) begin
            if (is_read) begin
              shreg      <= rd_data_in;
              sda_oe_out <= ~rd_data_in[7];
              state      <= ST_TX;
            end else begin
              sda_oe_out <= 1'b0;
              state      <= ST_REG;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            state      <= ST_WDAT;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            state      <= ST_IGN;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 1'b1;
          end else if (scl_fall) begin
            if (byte_done) begin
              sda_oe_out  <= 1'b0;
              bit_cnt     <= 4'h0;
              rd_addr_out <= ptr_step(rd_addr_out);
              state       <= ST_MACK;
            end else begin
              sda_oe_out <= ~shreg[3'h7 - bit_cnt[2:0]];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_sync[2];
          end else if (scl_fall) begin
            if (master_ack) begin
              shreg      <= rd_data_in;
              sda_oe_out <= ~rd_data_in[7];
              state      <= ST_TX;
            end else begin
              state <= ST_IGN;
            end
          end
        end
        ST_IGN: begin
          sda_oe_out <= 1'b0;
        end
        ST_IDLE: begin
          sda_oe_out <= 1'b0;
        end
        default: begin
          state      <= ST_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  rtc_write_fifo #(
    .WIDTH (`RTC_PTR_W + `RTC_BYTE_W),
    .DEPTH (`RTC_FIFO_DEPTH),
    .AW    (`RTC_FIFO_AW)
  ) u_write_fifo (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .in_valid  (fifo_push),
    .in_ready  (fifo_ready),
    .in_data   ({rd_addr_out, shreg}),
    .out_valid (wr_valid_out),
    .out_ready (wr_ready_in),
    .out_data  ({wr_addr_out, wr_data_out})
  );
endmodule

// ===== dv/i2c_ctrl_model.sv
// Behavioural serial bus controller: drives the clock and pulls data low.
`timescale 1ns/1ps
module i2c_ctrl_model (
  input  wire clk_in,     // Bench clock.
  input  wire sda_in,     // Resolved data line.
  output reg  scl_out,    // Serial clock, parked high.
  output reg  sda_low_out // High pulls data low.
);
  initial begin
    scl_out = 1'h1;
    sda_low_out = 1'h0;
  end
  // Low phase is longer than high so the target's late release never meets a rising clock.
  task step(input reg s, input reg d, input integer n);
    scl_out <= s;
    sda_low_out <= ~d;
    repeat (n) @(posedge clk_in);
  endtask
  task bitx(input reg d, output reg r);
    step(1'h0, d, 3);
    step(1'h1, d, 2);
    r = sda_in;
    step(1'h1, d, 1);
    step(1'h0, d, 2);
  endtask
  task start;
    step(scl_out, 1'h1, 3);
    step(1'h1, 1'h1, 2);
    step(1'h1, 1'h0, 2);
    step(1'h0, 1'h0, 2);
  endtask
  task stop;
    step(1'h0, 1'h0, 2);
    step(1'h1, 1'h0, 2);
    step(1'h1, 1'h1, 2);
  endtask
  task xfer(input reg [7:0] d, input reg ak, output reg [7:0] q, output reg ack);
    integer i;
    for (i = 7; i >= 0; i = i - 1) bitx(d[i], q[i]);
    bitx(ak, ack);
  endtask
endmodule

// ===== dv/rtc_i2c_checker_assertions.sv
// Port-level concurrent checks for the serial target block.
`timescale 1ns/1ps
`include "rtc_i2c_consts.vh"
module rtc_i2c_checker (
  input wire                  clk_in,       // Clock.
  input wire                  rst_in,       // Reset.
  input wire                  scl_in,       // Clock pin.
  input wire                  sda_in,       // Data pin.
  input wire                  sda_out,      // Drive value.
  input wire                  sda_oe_out,   // Pull enable.
  input wire [`RTC_PTR_W-1:0] rd_addr_out,  // Pointer.
  input wire                  wr_valid_out, // Write waiting.
  input wire                  wr_ready_in,  // Write taken.
  input wire [`RTC_PTR_W-1:0] wr_addr_out,  // Write register.
  input wire [7:0]            wr_data_out,  // Write byte.
  input wire                  busy_out      // Addressed.
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reset_ptr_a: assert property ($fell(rst_in) |-> rd_addr_out == `RTC_PTR_RESET && !busy_out)
    else $error("pointer or busy wrong after reset");
  drive_low_a: assert property (sda_out == 1'h0)
    else $error("data drive value is not low");
  // The synchroniser delays reaction by about three clocks, so look back that far.
  oe_scl_low_a: assert property ($changed(sda_oe_out) |-> !$past(scl_in, 3))
    else $error("data pull changed while serial clock high");
  idle_release_a: assert property (!busy_out |-> !sda_oe_out)
    else $error("data pulled while not addressed");
  stop_idle_a: assert property (scl_in && $rose(sda_in) |-> ##[1:6] !busy_out)
    else $error("stop did not return to idle");
  ptr_busy_a: assert property ($changed(rd_addr_out) |-> busy_out || $past(busy_out))
    else $error("pointer moved outside a transfer");
  fifo_hold_a: assert property (wr_valid_out && !wr_ready_in |=>
    wr_valid_out && $stable({wr_addr_out, wr_data_out}))
    else $error("stalled write changed");
  push_busy_a: assert property ($rose(wr_valid_out) |-> $past(busy_out))
    else $error("write appeared without a transfer");
  // A byte is queued together with its acknowledge pull, so a refused byte never reaches the array.
  write_ack_a: assert property ($rose(wr_valid_out) |-> sda_oe_out)
    else $error("write queued without acknowledge");
endmodule
bind rtc_i2c_target_access rtc_i2c_checker u_chk (.clk_in, .rst_in, .scl_in, .sda_in, .sda_out,
  .sda_oe_out, .rd_addr_out, .wr_valid_out, .wr_ready_in, .wr_addr_out, .wr_data_out, .busy_out);

// ===== dv/testbench.sv
// Self-checking bench: controller model, register contents and write drain.
`timescale 1ns/1ps
`include "rtc_i2c_consts.vh"
module testbench;
  function [7:0] reg_val(input [4:0] p);
    reg_val = {p, 3'h5} ^ 8'h3C;
  endfunction
  reg         clk_in = 1'h0;
  reg         rst_in = 1'h1;
  reg         wr_ready_in = 1'h0;
  reg         stall = 1'h0;
  wire        scl_in, m_low, sda_out, sda_oe_out, wr_valid_out, busy_out;
  wire        sda_in = ~m_low & (sda_oe_out ? sda_out : 1'h1);
  wire [4:0]  rd_addr_out, wr_addr_out;
  wire [7:0]  wr_data_out;
  wire [7:0]  rd_data_in = reg_val(rd_addr_out);
  reg  [12:0] exp_q[$];
  reg  [7:0]  q, a;
  reg         ack;
  integer     miscompares = 0, cmp_count = 0, seed = 32'hF10A, i;
  i2c_ctrl_model u_m (.clk_in, .sda_in, .scl_out(scl_in), .sda_low_out(m_low));
  rtc_i2c_target_access u_dut (.clk_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
    .rd_addr_out, .rd_data_in, .wr_valid_out, .wr_ready_in, .wr_addr_out, .wr_data_out,
    .busy_out);
  task chk(input [12:0] seen, input [12:0] expv, input [39:0] nm);
    cmp_count = cmp_count + 1;
    if (seen !== expv) begin
      miscompares = miscompares + 1;
      $display("FAIL %s expected %h seen %h", nm, expv, seen);
    end
  endtask
  task tx(input [7:0] d, input [0:0] nak);
    u_m.xfer(d, 1'h1, q, ack);
    chk(ack, nak, "ack");
  endtask
  task rx(input [4:0] p, input [0:0] last);
    u_m.xfer(8'hFF, last, q, ack);
    chk(q, reg_val(p), "rdata");
  endtask
  task adr(input [0:0] rd, input [0:0] nak);
    u_m.start;
    tx({`RTC_DEV_ID ^ {6'h0, nak}, rd}, nak);
  endtask
  task wr(input [7:0] ra, input [7:0] d, input [0:0] full);
    adr(1'h0, 1'h0);
    tx(ra, 1'h0);
    if (!full) exp_q.push_back({ra[4:0], d});
    tx(d, full);
    u_m.stop;
  endtask
  task close_out;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (wr_valid_out === 1'h1 && wr_ready_in === 1'h1)
      chk({wr_addr_out, wr_data_out}, exp_q.pop_front(), "write");
    wr_ready_in <= !stall && ($random(seed) % 2 != 0);
  end
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    close_out;
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'h0;
    repeat (4) @(posedge clk_in);
    adr(1'h1, 1'h0);
    rx(5'h00, 1'h1);
    u_m.stop;
    adr(1'h0, 1'h1);
    tx(8'h00, 1'h1);
    chk(busy_out, 1'h0, "busy");
    u_m.stop;
    stall <= 1'h1;
    // The ninth write finds the buffer full and is refused.
    for (i = 0; i < 9; i = i + 1) wr($random(seed), $random(seed), i == 8);
    stall <= 1'h0;
    for (i = 0; i < 4; i = i + 1) begin
      a = (i == 0) ? 8'hFE : $random(seed);
      adr(1'h0, 1'h0);
      tx(a, 1'h0);
      adr(1'h1, 1'h0);
      chk(busy_out, 1'h1, "busy");
      rx(a, 1'h0);
      rx(a + 8'h01, 1'h0);
      rx(a + 8'h02, 1'h1);
      u_m.stop;
    end
    adr(1'h1, 1'h0);
    rx(a + 8'h03, 1'h1);
    u_m.stop;
    repeat (100) @(posedge clk_in);
    chk(exp_q.size(), 13'h0, "drain");
    close_out;
  end
endmodule
